// ---- core/sd_timing_params.svh ----
// Offsets, field positions, reset values and timing counts of the SD timing register bank
`ifndef SD_TIMING_PARAMS_SVH
`define SD_TIMING_PARAMS_SVH

// Register subaddresses
`define ADDR_MASTER_SYNC_TIMING 8'h8B
`define ADDR_SUBCARRIER_FREQ_BYTE0 8'h8C
`define ADDR_SUBCARRIER_FREQ_BYTE1 8'h8D
`define ADDR_SUBCARRIER_FREQ_BYTE2 8'h8E
`define ADDR_SUBCARRIER_FREQ_BYTE3 8'h8F
`define ADDR_SUBCARRIER_PHASE_HIGH 8'h90
`define ADDR_CAPTION_EVEN_LOW 8'h91
`define ADDR_CAPTION_EVEN_HIGH 8'h92
`define ADDR_CAPTION_ODD_LOW 8'h93
`define ADDR_CAPTION_ODD_HIGH 8'h94
`define ADDR_PEDESTAL_MASK_ODD_A 8'h95
`define ADDR_PEDESTAL_MASK_ODD_B 8'h96
`define ADDR_PEDESTAL_MASK_EVEN_A 8'h97

// Reset values
`define RST_MASTER_SYNC_TIMING 8'h00
`define RST_SUBCARRIER_FREQ_BYTE0 8'h1F
`define RST_SUBCARRIER_FREQ_BYTE1 8'h7C
`define RST_SUBCARRIER_FREQ_BYTE2 8'hF0
`define RST_SUBCARRIER_FREQ_BYTE3 8'h21
`define RST_BYTE_ZERO 8'h00
`define READ_UNMAPPED 8'h00

// Fields of master_sync_timing
`define HS_WIDTH_LSB 0
`define VS_DELAY_LSB 2
`define RISE_EXTRA_BIT 4
`define VS_WIDTH_LSB 4
`define PIX_ADJUST_LSB 6
`define PHASE_LSB_SRC_LSB 6

// Timing modes
`define TIMING_MODE_1 2'h1
`define TIMING_MODE_2 2'h2

// Pulse widths and delays, in pixel clock cycles
`define LEN_CODE0 8'h01
`define LEN_CODE1 8'h04
`define LEN_CODE2 8'h10
`define LEN_CODE3 8'h80
`define DLY_CODE0 10'h000
`define DLY_CODE1 10'h004
`define DLY_CODE2 10'h008
`define DLY_CODE3 10'h012

// Extra rising edge delay: time in microseconds, pixel rate in kHz, derived count
`define RISE_EXTRA_US 32
`define PIX_RATE_KHZ 27000
`define RISE_EXTRA_CYC ((`RISE_EXTRA_US * `PIX_RATE_KHZ) / 1000)

// Pedestal mask line range
`define PED_FIRST_LINE 10'h00A
`define PED_LAST_ODD 10'h019
`define PED_LAST_EVEN 10'h011

`endif

// ---- core/sd_timing_pkg.sv ----
// Types of the SD timing register bank and its sync generator
package sd_timing_pkg;

	typedef enum logic [2:0] {
		VS_IDLE = 3'b001,
		VS_WAIT = 3'b010,
		VS_ACTIVE = 3'b100
	} vs_state_t;

	typedef struct packed {
		vs_state_t vs_state;
		logic [9:0] vs_cnt;
		logic [7:0] hs_cnt;
		logic hsync_n;
		logic vsync_n;
	} sync_state_t;

	typedef struct packed {
		logic [7:0] timing;
		logic [7:0] fsc0;
		logic [7:0] fsc1;
		logic [7:0] fsc2;
		logic [7:0] fsc3;
		logic [7:0] phase_high;
		logic [7:0] cc_even_low;
		logic [7:0] cc_even_high;
		logic [7:0] cc_odd_low;
		logic [7:0] cc_odd_high;
		logic [7:0] ped_odd_a;
		logic [7:0] ped_odd_b;
		logic [7:0] ped_even_a;
		logic [7:0] rdata;
		logic [31:0] fsc_word;
		logic [9:0] fsc_phase;
		logic [15:0] cc_even;
		logic [15:0] cc_odd;
		logic ped_off;
		logic [23:0] pix_pipe;
		logic [7:0] pix_out;
	} bank_state_t;

endpackage

// ---- core/sd_sync_gen.sv ----
// Master-mode horizontal and vertical sync pulse generator
`timescale 1ns/1ps
`include "sd_timing_params.svh"

module sd_sync_gen (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic pix_en,
	input wire logic master_en,
	input wire logic line_start,
	input wire logic field_start,
	input wire logic [7:0] hs_len,
	input wire logic [9:0] vs_delay,
	input wire logic [7:0] vs_len,
	input wire logic vs_whole_line,
	output logic hsync_n,
	output logic vsync_n
);

	sd_timing_pkg::sync_state_t st_r;
	sd_timing_pkg::sync_state_t st_nxt;

	logic line_go;

	assign line_go = pix_en && line_start;

	always_comb begin
		st_nxt = st_r;
		if (!master_en) begin
			// Slave mode: the timing fields are ignored and nothing is driven active
			st_nxt.vs_state = sd_timing_pkg::VS_IDLE;
			st_nxt.vs_cnt = 10'h000;
			st_nxt.hs_cnt = 8'h00;
		end else begin
			if (line_go) begin
				st_nxt.hs_cnt = hs_len;
			end else if (pix_en && st_r.hs_cnt != 8'h00) begin
				st_nxt.hs_cnt = st_r.hs_cnt - 8'h01;
			end
			case (st_r.vs_state)
				sd_timing_pkg::VS_IDLE: begin
					if (line_go && field_start) begin
						if (vs_delay == 10'h000) begin
							st_nxt.vs_state = sd_timing_pkg::VS_ACTIVE;
							st_nxt.vs_cnt = {2'b00, vs_len};
						end else begin
							st_nxt.vs_state = sd_timing_pkg::VS_WAIT;
							st_nxt.vs_cnt = vs_delay;
						end
					end
				end
				sd_timing_pkg::VS_WAIT: begin
					if (pix_en) begin
						if (st_r.vs_cnt == 10'h001) begin
							st_nxt.vs_state = sd_timing_pkg::VS_ACTIVE;
							st_nxt.vs_cnt = {2'b00, vs_len};
						end else begin
							st_nxt.vs_cnt = st_r.vs_cnt - 10'h001;
						end
					end
				end
				sd_timing_pkg::VS_ACTIVE: begin
					// Outside mode 2 the pulse runs until the next line begins
					if (vs_whole_line) begin
						if (line_go) begin
							st_nxt.vs_state = sd_timing_pkg::VS_IDLE;
						end
					end else if (pix_en) begin
						if (st_r.vs_cnt == 10'h001) begin
							st_nxt.vs_state = sd_timing_pkg::VS_IDLE;
						end
						st_nxt.vs_cnt = st_r.vs_cnt - 10'h001;
					end
				end
				default: begin
					st_nxt.vs_state = sd_timing_pkg::VS_IDLE;
				end
			endcase
		end
		st_nxt.hsync_n = (st_nxt.hs_cnt == 8'h00);
		st_nxt.vsync_n = (st_nxt.vs_state != sd_timing_pkg::VS_ACTIVE);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{vs_state: sd_timing_pkg::VS_IDLE, vs_cnt: 10'h000, hs_cnt: 8'h00,
				hsync_n: 1'b1, vsync_n: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hsync_n = st_r.hsync_n;
	assign vsync_n = st_r.vsync_n;

endmodule

// ---- core/sd_timing_subcarrier_regs.sv ----
// SD timing, subcarrier, closed caption and pedestal mask register bank
//
// How it works
// - Master hsync width from bits 1:0: 1, 4, 16 or 128 pixel clocks.
// - Sync timing fields in bits 5:0 act only when sync master is selected.
// - Vsync delayed after hsync by 0, 4, 8 or 18 pixel clocks.
// - Mode 1 only: bit 4 adds 32 us to the vsync rising delay.
// - Mode 2 only: bits 5:4 set vsync width 1, 4, 16 or 128.
// - Bits 7:6 shift hsync to pixel data alignment by 0 to 3 pixel clocks.
// - Subcarrier bytes reset to 1F, 7C, F0, 21 from lowest address.
// - Phase bits 9:2 come from a byte register resetting to zero.
// - Phase bits 1:0 come from bits 7:6 of the scale LSB register.
// - Two 16-bit caption payloads, even and odd field, reset to zero.
// - Odd field masks map lines 10 to 25; a one removes pedestal.
// - Even field mask maps lines 10 to 17; a one removes pedestal.
`timescale 1ns/1ps
`include "sd_timing_params.svh"

module sd_timing_subcarrier_regs (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sync_master,
	input wire logic [1:0] timing_mode,
	input wire logic [7:0] scale_lsb,
	input wire logic pix_en,
	input wire logic line_start,
	input wire logic field_start,
	input wire logic field_odd,
	input wire logic [9:0] line_num,
	input wire logic [7:0] pix_in,
	output logic [7:0] pix_out,
	output logic hsync_n,
	output logic vsync_n,
	output logic [31:0] subcarrier_freq,
	output logic [9:0] subcarrier_phase,
	output logic [15:0] caption_even,
	output logic [15:0] caption_odd,
	output logic pedestal_off
);

	////////////////////////////////////////////////////////////////////////////////
	// Code tables

	function automatic logic [7:0] pulse_len(input logic [1:0] code);
		logic [7:0] len;
		len = `LEN_CODE0;
		case (code)
			2'h1: len = `LEN_CODE1;
			2'h2: len = `LEN_CODE2;
			2'h3: len = `LEN_CODE3;
			default: len = `LEN_CODE0;
		endcase
		return len;
	endfunction

	function automatic logic [9:0] hv_delay(input logic [1:0] code);
		logic [9:0] dly;
		dly = `DLY_CODE0;
		case (code)
			2'h1: dly = `DLY_CODE1;
			2'h2: dly = `DLY_CODE2;
			2'h3: dly = `DLY_CODE3;
			default: dly = `DLY_CODE0;
		endcase
		return dly;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	sd_timing_pkg::bank_state_t st_r;
	sd_timing_pkg::bank_state_t st_nxt;

	logic [7:0] hs_len;
	logic [9:0] vs_delay;
	logic [7:0] vs_len;
	logic vs_whole_line;
	logic [15:0] ped_odd_mask;
	logic [9:0] ped_idx;
	logic [1:0] pix_adj;

	always_comb begin
		hs_len = pulse_len(st_r.timing[`HS_WIDTH_LSB +: 2]);
		vs_delay = hv_delay(st_r.timing[`VS_DELAY_LSB +: 2]);
		// Bit 4 serves two modes; each reading is used only in its own mode
		if (timing_mode == `TIMING_MODE_1 && st_r.timing[`RISE_EXTRA_BIT]) begin
			vs_delay = vs_delay + 10'(`RISE_EXTRA_CYC);
		end
		if (timing_mode == `TIMING_MODE_2) begin
			vs_len = pulse_len(st_r.timing[`VS_WIDTH_LSB +: 2]);
			vs_whole_line = 1'b0;
		end else begin
			vs_len = `LEN_CODE0;
			vs_whole_line = 1'b1;
		end
	end

	assign ped_odd_mask = {st_r.ped_odd_b, st_r.ped_odd_a};
	assign ped_idx = line_num - `PED_FIRST_LINE;
	assign pix_adj = st_r.timing[`PIX_ADJUST_LSB +: 2];

	always_comb begin
		st_nxt = st_r;

		// Register writes
		if (reg_wr) begin
			if (reg_addr == `ADDR_MASTER_SYNC_TIMING) begin
				st_nxt.timing = reg_wdata;
			end else if (reg_addr == `ADDR_SUBCARRIER_FREQ_BYTE0) begin
				st_nxt.fsc0 = reg_wdata;
			end else if (reg_addr == `ADDR_SUBCARRIER_FREQ_BYTE1) begin
				st_nxt.fsc1 = reg_wdata;
			end else if (reg_addr == `ADDR_SUBCARRIER_FREQ_BYTE2) begin
				st_nxt.fsc2 = reg_wdata;
			end else if (reg_addr == `ADDR_SUBCARRIER_FREQ_BYTE3) begin
				st_nxt.fsc3 = reg_wdata;
			end else if (reg_addr == `ADDR_SUBCARRIER_PHASE_HIGH) begin
				st_nxt.phase_high = reg_wdata;
			end else if (reg_addr == `ADDR_CAPTION_EVEN_LOW) begin
				st_nxt.cc_even_low = reg_wdata;
			end else if (reg_addr == `ADDR_CAPTION_EVEN_HIGH) begin
				st_nxt.cc_even_high = reg_wdata;
			end else if (reg_addr == `ADDR_CAPTION_ODD_LOW) begin
				st_nxt.cc_odd_low = reg_wdata;
			end else if (reg_addr == `ADDR_CAPTION_ODD_HIGH) begin
				st_nxt.cc_odd_high = reg_wdata;
			end else if (reg_addr == `ADDR_PEDESTAL_MASK_ODD_A) begin
				st_nxt.ped_odd_a = reg_wdata;
			end else if (reg_addr == `ADDR_PEDESTAL_MASK_ODD_B) begin
				st_nxt.ped_odd_b = reg_wdata;
			end else if (reg_addr == `ADDR_PEDESTAL_MASK_EVEN_A) begin
				st_nxt.ped_even_a = reg_wdata;
			end
		end

		// Read data follows the address one cycle later; foreign addresses read zero
		if (reg_addr == `ADDR_MASTER_SYNC_TIMING) begin
			st_nxt.rdata = st_r.timing;
		end else if (reg_addr == `ADDR_SUBCARRIER_FREQ_BYTE0) begin
			st_nxt.rdata = st_r.fsc0;
		end else if (reg_addr == `ADDR_SUBCARRIER_FREQ_BYTE1) begin
			st_nxt.rdata = st_r.fsc1;
		end else if (reg_addr == `ADDR_SUBCARRIER_FREQ_BYTE2) begin
			st_nxt.rdata = st_r.fsc2;
		end else if (reg_addr == `ADDR_SUBCARRIER_FREQ_BYTE3) begin
			st_nxt.rdata = st_r.fsc3;
		end else if (reg_addr == `ADDR_SUBCARRIER_PHASE_HIGH) begin
			st_nxt.rdata = st_r.phase_high;
		end else if (reg_addr == `ADDR_CAPTION_EVEN_LOW) begin
			st_nxt.rdata = st_r.cc_even_low;
		end else if (reg_addr == `ADDR_CAPTION_EVEN_HIGH) begin
			st_nxt.rdata = st_r.cc_even_high;
		end else if (reg_addr == `ADDR_CAPTION_ODD_LOW) begin
			st_nxt.rdata = st_r.cc_odd_low;
		end else if (reg_addr == `ADDR_CAPTION_ODD_HIGH) begin
			st_nxt.rdata = st_r.cc_odd_high;
		end else if (reg_addr == `ADDR_PEDESTAL_MASK_ODD_A) begin
			st_nxt.rdata = st_r.ped_odd_a;
		end else if (reg_addr == `ADDR_PEDESTAL_MASK_ODD_B) begin
			st_nxt.rdata = st_r.ped_odd_b;
		end else if (reg_addr == `ADDR_PEDESTAL_MASK_EVEN_A) begin
			st_nxt.rdata = st_r.ped_even_a;
		end else begin
			st_nxt.rdata = `READ_UNMAPPED;
		end

		// Assembled words, one cycle behind the byte registers
		st_nxt.fsc_word = {st_r.fsc3, st_r.fsc2, st_r.fsc1, st_r.fsc0};
		st_nxt.fsc_phase = {st_r.phase_high, scale_lsb[`PHASE_LSB_SRC_LSB +: 2]};
		st_nxt.cc_even = {st_r.cc_even_high, st_r.cc_even_low};
		st_nxt.cc_odd = {st_r.cc_odd_high, st_r.cc_odd_low};

		// Pedestal suppression for the current line; lines outside the masks keep it
		st_nxt.ped_off = 1'b0;
		if (line_num >= `PED_FIRST_LINE) begin
			if (field_odd && line_num <= `PED_LAST_ODD) begin
				st_nxt.ped_off = ped_odd_mask[ped_idx[3:0]];
			end else if (!field_odd && line_num <= `PED_LAST_EVEN) begin
				st_nxt.ped_off = st_r.ped_even_a[ped_idx[2:0]];
			end
		end

		// Pixel alignment: the common one-stage latency is the same for every code
		if (pix_en) begin
			st_nxt.pix_pipe = {st_r.pix_pipe[15:0], pix_in};
			if (pix_adj == 2'h0) begin
				st_nxt.pix_out = pix_in;
			end else if (pix_adj == 2'h1) begin
				st_nxt.pix_out = st_r.pix_pipe[7:0];
			end else if (pix_adj == 2'h2) begin
				st_nxt.pix_out = st_r.pix_pipe[15:8];
			end else begin
				st_nxt.pix_out = st_r.pix_pipe[23:16];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{
				timing: `RST_MASTER_SYNC_TIMING,
				fsc0: `RST_SUBCARRIER_FREQ_BYTE0,
				fsc1: `RST_SUBCARRIER_FREQ_BYTE1,
				fsc2: `RST_SUBCARRIER_FREQ_BYTE2,
				fsc3: `RST_SUBCARRIER_FREQ_BYTE3,
				phase_high: `RST_BYTE_ZERO,
				cc_even_low: `RST_BYTE_ZERO,
				cc_even_high: `RST_BYTE_ZERO,
				cc_odd_low: `RST_BYTE_ZERO,
				cc_odd_high: `RST_BYTE_ZERO,
				ped_odd_a: `RST_BYTE_ZERO,
				ped_odd_b: `RST_BYTE_ZERO,
				ped_even_a: `RST_BYTE_ZERO,
				rdata: `READ_UNMAPPED,
				fsc_word: {`RST_SUBCARRIER_FREQ_BYTE3, `RST_SUBCARRIER_FREQ_BYTE2,
					`RST_SUBCARRIER_FREQ_BYTE1, `RST_SUBCARRIER_FREQ_BYTE0},
				fsc_phase: 10'h000,
				cc_even: 16'h0000,
				cc_odd: 16'h0000,
				ped_off: 1'b0,
				pix_pipe: 24'h000000,
				pix_out: 8'h00
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sync generation, gated by master mode

	sd_sync_gen u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pix_en(pix_en),
		.master_en(sync_master),
		.line_start(line_start),
		.field_start(field_start),
		.hs_len(hs_len),
		.vs_delay(vs_delay),
		.vs_len(vs_len),
		.vs_whole_line(vs_whole_line),
		.hsync_n(hsync_n),
		.vsync_n(vsync_n)
	);

	assign reg_rdata = st_r.rdata;
	assign subcarrier_freq = st_r.fsc_word;
	assign subcarrier_phase = st_r.fsc_phase;
	assign caption_even = st_r.cc_even;
	assign caption_odd = st_r.cc_odd;
	assign pedestal_off = st_r.ped_off;
	assign pix_out = st_r.pix_out;

endmodule

// ---- bench/sd_timing_properties.sv ----
// Port-level checks of the SD timing register bank
`timescale 1ns/1ps
module sd_timing_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic sync_master,
	input wire logic [1:0] timing_mode,
	input wire logic [7:0] scale_lsb,
	input wire logic pix_en,
	input wire logic line_start,
	input wire logic field_odd,
	input wire logic [9:0] line_num,
	input wire logic hsync_n,
	input wire logic vsync_n,
	input wire logic [9:0] subcarrier_phase,
	input wire logic pedestal_off
);
	logic [7:0] tim_r, hlen_r, vlen_r, hlow_r, vlow_r;
	logic [10:0] since_r, since_c, dexp_c;
	logic hprev_r, vprev_r, vchk_r;
	function automatic logic [7:0] plen(input logic [1:0] c);
		return c[1] ? (c[0] ? 8'h80 : 8'h10) : (c[0] ? 8'h04 : 8'h01);
	endfunction
	assign since_c = (hprev_r && !hsync_n) ? 11'h000 : since_r;
	assign dexp_c = (tim_r[3:2] == 2'h3 ? 11'h012 : {7'h00, tim_r[3:2], 2'h0})
		+ (timing_mode == 2'h1 && tim_r[4] ? 11'h360 : 11'h000);
	// Lengths latched at the falling edge, so a later write cannot skew a check
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			{tim_r, hlen_r, vlen_r, hlow_r, vlow_r} <= 40'h0;
			{since_r, hprev_r, vprev_r, vchk_r} <= 14'h0006;
		end else begin
			if (reg_wr && reg_addr == 8'h8B)
				tim_r <= reg_wdata;
			// Widths and delays are counted in pixel enables, not in clocks
			since_r <= since_c + {10'h000, pix_en};
			hprev_r <= hsync_n;
			vprev_r <= vsync_n;
			hlow_r <= hsync_n ? 8'h00 : hlow_r + {7'h00, pix_en};
			vlow_r <= vsync_n ? 8'h00 : vlow_r + {7'h00, pix_en};
			if (hprev_r && !hsync_n)
				hlen_r <= plen(tim_r[1:0]);
			if (vprev_r && !vsync_n) begin
				vlen_r <= plen(tim_r[5:4]);
				vchk_r <= timing_mode == 2'h2;
			end
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	chk_hs_start: assert property (sync_master && pix_en && line_start |=> !hsync_n)
		else $error("hsync did not start");
	chk_hs_width: assert property ($rose(hsync_n) && $past(sync_master) |-> hlow_r == hlen_r)
		else $error("hsync width wrong");
	chk_slave_idle: assert property (!sync_master |=> hsync_n && vsync_n)
		else $error("sync driven in slave mode");
	chk_vs_delay: assert property ($fell(vsync_n) |-> since_c == dexp_c)
		else $error("vsync delay wrong");
	chk_vs_width: assert property ($rose(vsync_n) && vchk_r && $past(sync_master)
		|-> vlow_r == vlen_r) else $error("vsync width wrong");
	chk_phase_low: assert property ({subcarrier_phase[1:0], 6'h00} == ($past(scale_lsb) & 8'hC0))
		else $error("phase low bits wrong");
	chk_ped_odd_range: assert property ($past(line_num) < 10'h00A || $past(line_num) > 10'h019
		|-> !pedestal_off) else $error("pedestal off outside lines");
	chk_ped_even_range: assert property (!$past(field_odd) && $past(line_num) > 10'h011
		|-> !pedestal_off) else $error("pedestal off outside even lines");
endmodule
bind sd_timing_subcarrier_regs sd_timing_checker sd_timing_checker_i (.sys_clk(sys_clk),
	.reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.sync_master(sync_master), .timing_mode(timing_mode), .scale_lsb(scale_lsb),
	.pix_en(pix_en), .line_start(line_start), .field_odd(field_odd), .line_num(line_num),
	.hsync_n(hsync_n), .vsync_n(vsync_n), .subcarrier_phase(subcarrier_phase),
	.pedestal_off(pedestal_off));

// ---- bench/video_source.sv ----
// Upstream source model: line and field timing with a counting pixel stream
`timescale 1ns/1ps
module video_source (
	input wire logic sys_clk,
	input wire logic run,
	input wire logic [10:0] line_len,
	input wire logic [9:0] field_lines,
	output logic pix_en,
	output logic line_start,
	output logic field_start,
	output logic field_odd,
	output logic [9:0] line_num,
	output logic [7:0] pix_in
);
	logic [10:0] pos_r;
	initial begin
		pix_en = 1'b1;
		pos_r = 11'h000;
		line_num = 10'h000;
		field_odd = 1'b0;
		pix_in = 8'h00;
	end
	assign line_start = run && pos_r == 11'h000;
	assign field_start = line_start && line_num == 10'h000;
	// A counting pixel stream makes the alignment delay readable as a difference
	// Pixel enable at half the clock rate, so the enable gating of the block is exercised
	always @(negedge sys_clk) begin
		pix_en <= !pix_en;
		if (pix_en)
			pix_in <= pix_in + 8'h01;
		if (!run) begin
			pos_r <= 11'h000;
			line_num <= 10'h000;
		end else if (pix_en && pos_r == line_len - 11'h001) begin
			pos_r <= 11'h000;
			if (line_num == field_lines - 10'h001) begin
				line_num <= 10'h000;
				field_odd <= !field_odd;
			end else begin
				line_num <= line_num + 10'h001;
			end
		end else if (pix_en) begin
			pos_r <= pos_r + 11'h001;
		end
	end
endmodule

// ---- bench/sd_timing_subcarrier_regs_tb_top.sv ----
// Self-checking bench for the SD timing register bank
`timescale 1ns/1ps
module sd_timing_subcarrier_regs_tb_top;
	logic sys_clk, reset_n, reg_wr, sync_master, pix_en, line_start, field_start, field_odd;
	logic hsync_n, vsync_n, pedestal_off, run, ped_chk, po_r;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, scale_lsb, pix_in, pix_out;
	logic [1:0] timing_mode;
	logic [9:0] line_num, subcarrier_phase, field_lines, pl_r;
	logic [10:0] line_len;
	logic [31:0] subcarrier_freq;
	logic [15:0] caption_even, caption_odd;
	logic [7:0] dif [4];
	int miscompares, n_compared;
	localparam logic [15:0] odd_mask = 16'hA5C3;
	localparam logic [7:0] even_mask = 8'h5A;
	localparam logic [7:0] rst_tab [13] = '{8'h00, 8'h1F, 8'h7C, 8'hF0, 8'h21, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	sd_timing_subcarrier_regs sd_timing_subcarrier_regs_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.sync_master(sync_master), .timing_mode(timing_mode), .scale_lsb(scale_lsb),
		.pix_en(pix_en), .line_start(line_start), .field_start(field_start),
		.field_odd(field_odd), .line_num(line_num), .pix_in(pix_in), .pix_out(pix_out),
		.hsync_n(hsync_n), .vsync_n(vsync_n), .subcarrier_freq(subcarrier_freq),
		.subcarrier_phase(subcarrier_phase), .caption_even(caption_even),
		.caption_odd(caption_odd), .pedestal_off(pedestal_off));
	video_source video_source_i (.sys_clk(sys_clk), .run(run), .line_len(line_len),
		.field_lines(field_lines), .pix_en(pix_en), .line_start(line_start),
		.field_start(field_start), .field_odd(field_odd), .line_num(line_num), .pix_in(pix_in));

	////////////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] pat(input int i);
		return 8'h13 + 8'(i * 41);
	endfunction
	function automatic logic ped_exp(input logic [9:0] ln, input logic odd);
		if (ln < 10'h00A || ln > (odd ? 10'h019 : 10'h011))
			return 1'b0;
		return odd ? odd_mask[ln - 10'h00A] : even_mask[ln - 10'h00A];
	endfunction
	task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(negedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data is registered: sample just after the edge that follows the address
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		reg_addr <= a;
		@(posedge sys_clk);
		#1;
		cmp_byte("reg_rdata", exp, reg_rdata);
	endtask
	task automatic run_lines(input logic [10:0] len, input logic [9:0] fl, input int n);
		@(negedge sys_clk);
		line_len <= len;
		field_lines <= fl;
		run <= 1'b1;
		// One pixel every second clock
		repeat (2 * n * int'(len)) @(negedge sys_clk);
		run <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		if (ped_chk)
			cmp_word("pedestal_off", {31'h0, ped_exp(pl_r, po_r)}, {31'h0, pedestal_off});
		pl_r <= line_num;
		po_r <= field_odd;
	end
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		miscompares++;
		end_of_test();
	end
	initial begin
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		sync_master = 1'b0;
		timing_mode = 2'h0;
		scale_lsb = 8'h00;
		run = 1'b0;
		ped_chk = 1'b0;
		line_len = 11'h0C8;
		field_lines = 10'h002;
		miscompares = 0;
		n_compared = 0;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 13; i++)
			rd(8'h8B + 8'(i), rst_tab[i]);
		cmp_word("subcarrier_freq", 32'h21F07C1F, subcarrier_freq);
		cmp_word("subcarrier_phase", 32'h0, {22'h0, subcarrier_phase});
		cmp_word("captions", 32'h0, {caption_even, caption_odd});
		@(negedge sys_clk);
		scale_lsb <= 8'hC0;
		for (int i = 0; i < 13; i++)
			wr(8'h8B + 8'(i), pat(i));
		wr(8'h98, 8'hFF);
		for (int i = 0; i < 13; i++)
			rd(8'h8B + 8'(i), pat(i));
		rd(8'h98, 8'h00);
		rd(8'h8A, 8'h00);
		cmp_word("subcarrier_freq", {pat(4), pat(3), pat(2), pat(1)}, subcarrier_freq);
		cmp_word("subcarrier_phase", {22'h0, pat(5), 2'h3}, {22'h0, subcarrier_phase});
		cmp_word("captions", {pat(7), pat(6), pat(9), pat(8)}, {caption_even, caption_odd});
		wr(8'h95, odd_mask[7:0]);
		wr(8'h96, odd_mask[15:8]);
		wr(8'h97, even_mask);
		// Every field code walked at once; the checker judges the sync pulses
		@(negedge sys_clk);
		sync_master <= 1'b1;
		timing_mode <= 2'h2;
		for (int k = 0; k < 4; k++) begin
			wr(8'h8B, {4{2'(k)}});
			run_lines(11'h0C8, 10'h002, 4);
			// Only at a pixel edge do input and output belong to one pixel slot
			@(posedge sys_clk);
			while (!pix_en) @(posedge sys_clk);
			#1;
			dif[k] = pix_in - pix_out;
			cmp_byte("pixel adjust", 8'(k), dif[k]);
		end
		@(negedge sys_clk);
		timing_mode <= 2'h1;
		wr(8'h8B, 8'h10);
		run_lines(11'h3E8, 10'h002, 4);
		@(negedge sys_clk);
		timing_mode <= 2'h3;
		wr(8'h8B, 8'h1C);
		run_lines(11'h0C8, 10'h002, 4);
		@(negedge sys_clk);
		sync_master <= 1'b0;
		ped_chk <= 1'b1;
		run_lines(11'h028, 10'h01C, 56);
		ped_chk <= 1'b0;
		@(posedge sys_clk);
		#1;
		cmp_byte("sync idle", 8'h03, {6'h0, hsync_n, vsync_n});
		end_of_test();
	end
endmodule
